// file: verilog/fcr_pkg.sv
// Package for the floppy configuration register bank
package fcr_pkg;

	// ****************************************************************
	// Register indexes and reset values
	// ****************************************************************
	localparam logic [7:0] FCR_IDX_MODE   = 8'hf0;
	localparam logic [7:0] FCR_IDX_OPTION = 8'hf1;
	localparam logic [7:0] FCR_IDX_TYPE   = 8'hf2;
	localparam logic [7:0] FCR_IDX_LDN    = 8'h07;
	localparam logic [7:0] FCR_RST_MODE   = 8'h0e;
	localparam logic [7:0] FCR_RST_OPTION = 8'h00;
	localparam logic [7:0] FCR_RST_TYPE   = 8'hff;
	localparam logic [7:0] FCR_LDN_FLOPPY = 8'h00;

	// ****************************************************************
	// Configuration port addresses
	// ****************************************************************
	localparam logic [15:0] FCR_PORT_STRAP0 = 16'h002e;
	localparam logic [15:0] FCR_PORT_STRAP1 = 16'h004e;

	// ****************************************************************
	// Field layouts
	// ****************************************************************
	typedef struct packed {
		logic       tristate;
		logic       push_pull;
		logic       reserved5;
		logic       drive_pair_exchange;
		logic [1:0] iface_mode;
		logic       non_burst_dma;
		logic       enhanced_mode;
	} fcr_mode_t;

	typedef struct packed {
		logic [3:0] reserved7_4;
		logic [1:0] density_sel;
		logic       reserved1;
		logic       force_wp;
	} fcr_option_t;

	typedef struct packed {
		logic [1:0] drive_c;
		logic [1:0] drive_b;
		logic [1:0] drive_a;
	} fcr_types_t;

	localparam logic [1:0] FCR_DENS_FORCE1 = 2'h2;
	localparam logic [1:0] FCR_DENS_FORCE0 = 2'h3;

	// Drive controls toward the pins, active low like the pins
	typedef struct packed {
		logic drive0_select_n;
		logic drive1_select_n;
		logic motor0_on_n;
		logic motor1_on_n;
	} fcr_drive_t;

endpackage

// file: verilog/fcr_floppy_cfg.sv
// Floppy configuration registers and their effect on the floppy pins
// What this block does
// - Power-on and host-bus reset restore defaults
// - Soft reset leaves these registers untouched
// - Mode bit 0 selects enhanced floppy mode
// - Mode bit 1 selects non-burst DMA
// - Mode bits 3:2 select interface mode
// - Mode bit 4 exchanges drive 0/1 outputs
// - Mode bit 6 selects push-pull over open-drain
// - Mode bit 7 tri-states floppy outputs
// - Bits 6,7 do not touch parallel-port floppy
// - Forced write-protect when either drive selected
// - Write-protect is OR of three terms
// - Forced write-protect also on parallel port
// - Option bits 3:2 force density output
// - Drive 0 is always the boot drive
// - Type register holds drive A/B codes
// - Type bits 5:4 keep written value
// - Config port at 0x02e or 0x04e by strap
`timescale 1ns/100ps

module fcr_floppy_cfg
	import fcr_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        host_bus_reset_n,
	input  wire logic        soft_reset,
	input  wire logic        config_port_strap,
	input  wire logic [15:0] port_base_new,
	input  wire logic        port_base_load,
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_rvalid,
	output logic      [15:0] config_port_base,
	input  wire fcr_drive_t  core_drive,
	input  wire logic        core_density,
	input  wire logic        write_protect_in_n,
	input  wire logic        floppy_wp_disable,
	input  wire logic        pport_route,
	output logic             core_write_protect,
	output logic             floppy_status_a_wp,
	output fcr_drive_t       drive_out,
	output fcr_drive_t       drive_oe,
	output logic             density_out,
	output logic             density_oe,
	output fcr_drive_t       pport_drive_out,
	output logic             pport_density_out,
	output logic             enhanced_mode,
	output logic             non_burst_dma,
	output logic      [1:0]  iface_mode,
	output logic             boot_drive
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_s1_q;
	logic rst_s2_q;
	logic hard_rst_n;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Host-bus reset acts as a synchronous hard reset
	assign hard_rst_n = rst_s2_q && host_bus_reset_n;

	// ****************************************************************
	// Configuration port location
	// ****************************************************************
	logic [15:0] port_base_q;
	logic        strap_taken_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_base_q   <= FCR_PORT_STRAP0;
			strap_taken_q <= 1'b0;
		end else if (!strap_taken_q && rst_s2_q) begin
			port_base_q   <= config_port_strap ? FCR_PORT_STRAP1
			                                   : FCR_PORT_STRAP0;
			strap_taken_q <= 1'b1;
		end else if (port_base_load) begin
			port_base_q <= port_base_new;
		end
	end

	assign config_port_base = port_base_q;

	// ****************************************************************
	// Index and data port access
	// ****************************************************************
	logic [7:0] index_q;
	logic [7:0] ldn_q;
	logic       idx_hit;
	logic       dat_hit;
	logic       fdd_sel;

	assign idx_hit = io_addr == port_base_q;
	assign dat_hit = io_addr == port_base_q + 16'h0001;
	assign fdd_sel = ldn_q == FCR_LDN_FLOPPY;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			index_q <= 8'h00;
		end else if (io_wr && idx_hit) begin
			index_q <= io_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ldn_q <= FCR_LDN_FLOPPY;
		end else if (!hard_rst_n) begin
			ldn_q <= FCR_LDN_FLOPPY;
		end else if (io_wr && dat_hit && index_q == FCR_IDX_LDN) begin
			ldn_q <= io_wdata;
		end
	end

	// ****************************************************************
	// Floppy configuration registers
	// ****************************************************************
	fcr_mode_t   mode_q;
	fcr_option_t option_q;
	logic [7:0]  type_q;
	logic        cfg_wr;

	assign cfg_wr = io_wr && dat_hit && fdd_sel;

	// Soft reset is deliberately not an input to these registers
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= fcr_mode_t'(FCR_RST_MODE);
		end else if (!hard_rst_n) begin
			mode_q <= fcr_mode_t'(FCR_RST_MODE);
		end else if (cfg_wr && index_q == FCR_IDX_MODE) begin
			mode_q <= fcr_mode_t'(io_wdata);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			option_q <= fcr_option_t'(FCR_RST_OPTION);
		end else if (!hard_rst_n) begin
			option_q <= fcr_option_t'(FCR_RST_OPTION);
		end else if (cfg_wr && index_q == FCR_IDX_OPTION) begin
			option_q <= fcr_option_t'(io_wdata);
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			type_q <= FCR_RST_TYPE;
		end else if (!hard_rst_n) begin
			type_q <= FCR_RST_TYPE;
		end else if (cfg_wr && index_q == FCR_IDX_TYPE) begin
			type_q <= io_wdata;
		end
	end

	// Read data
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_rdata  <= 8'h00;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= io_rd && (idx_hit || dat_hit);
			if (io_rd && idx_hit) begin
				io_rdata <= index_q;
			end else if (io_rd && dat_hit) begin
				if (index_q == FCR_IDX_LDN) begin
					io_rdata <= ldn_q;
				end else if (fdd_sel && index_q == FCR_IDX_MODE) begin
					io_rdata <= mode_q;
				end else if (fdd_sel && index_q == FCR_IDX_OPTION) begin
					io_rdata <= option_q;
				end else if (fdd_sel && index_q == FCR_IDX_TYPE) begin
					io_rdata <= type_q;
				end else begin
					io_rdata <= 8'h00;
				end
			end
		end
	end

	// ****************************************************************
	// Mode outputs to the controller core
	// ****************************************************************
	assign enhanced_mode = mode_q.enhanced_mode;
	assign non_burst_dma = mode_q.non_burst_dma;
	assign iface_mode    = mode_q.iface_mode;
	assign boot_drive    = 1'b0;

	// ****************************************************************
	// Write protect
	// ****************************************************************
	logic any_sel;
	logic wp_active;

	always_comb begin
		any_sel = !core_drive.drive0_select_n
		       || !core_drive.drive1_select_n;
		// Forcing holds for pin and parallel-port routing alike
		wp_active = (any_sel && option_q.force_wp)
		         || !write_protect_in_n
		         || floppy_wp_disable;
	end

	assign core_write_protect = wp_active;
	assign floppy_status_a_wp = wp_active;

	// ****************************************************************
	// Drive outputs, density and pin drivers
	// ****************************************************************
	fcr_drive_t swapped;
	logic       dens;

	always_comb begin
		swapped = core_drive;
		if (mode_q.drive_pair_exchange) begin
			swapped.drive0_select_n = core_drive.drive1_select_n;
			swapped.drive1_select_n = core_drive.drive0_select_n;
			swapped.motor0_on_n     = core_drive.motor1_on_n;
			swapped.motor1_on_n     = core_drive.motor0_on_n;
		end
		unique case (option_q.density_sel)
			FCR_DENS_FORCE1: dens = 1'b1;
			FCR_DENS_FORCE0: dens = 1'b0;
			default:         dens = core_density;
		endcase
	end

	// Open drain drives only the low level; tri-state drives nothing
	always_comb begin
		drive_out   = swapped;
		density_out = dens;
		if (mode_q.tristate || pport_route) begin
			drive_oe   = '0;
			density_oe = 1'b0;
		end else if (mode_q.push_pull) begin
			drive_oe   = '1;
			density_oe = 1'b1;
		end else begin
			drive_oe   = ~swapped;
			density_oe = !dens;
		end
	end

	// Parallel-port copy ignores bits 6 and 7
	assign pport_drive_out   = pport_route ? swapped : '1;
	assign pport_density_out = pport_route ? dens : 1'b1;

endmodule

// file: tb/fcr_floppy_cfg_checker.sv
// Assertion checker for the floppy configuration registers
`timescale 1ns/100ps
module fcr_floppy_cfg_checker
	import fcr_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        host_bus_reset_n,
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic        io_rvalid,
	input wire logic [15:0] config_port_base,
	input wire fcr_drive_t  core_drive,
	input wire logic        write_protect_in_n,
	input wire logic        floppy_wp_disable,
	input wire logic        core_write_protect,
	input wire logic        floppy_status_a_wp,
	input wire logic        enhanced_mode,
	input wire logic        non_burst_dma,
	input wire logic [1:0]  iface_mode,
	input wire logic        boot_drive
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_read_answer: assert property (
		io_rd && io_addr == config_port_base + 16'h1 |=> io_rvalid)
		else $error("read not answered");
	a_no_answer: assert property (
		!io_rd |=> !io_rvalid)
		else $error("answer without read");
	a_boot_drive: assert property (
		boot_drive == 1'b0)
		else $error("boot drive not 0");
	a_wp_input: assert property (
		!write_protect_in_n |-> core_write_protect)
		else $error("wp input lost");
	a_wp_status: assert property (
		floppy_status_a_wp == core_write_protect)
		else $error("status wp differs");
	a_wp_disable: assert property (
		floppy_wp_disable |-> core_write_protect)
		else $error("wp disable lost");
	a_wp_idle: assert property (
		core_drive.drive0_select_n && core_drive.drive1_select_n
		&& write_protect_in_n && !floppy_wp_disable
		|-> !core_write_protect)
		else $error("wp without cause");
	a_mode_steady: assert property (
		$changed({iface_mode, enhanced_mode, non_burst_dma})
		|-> $past(io_wr) || !$past(host_bus_reset_n))
		else $error("mode changed alone");
	c_read: cover property (io_rvalid);
	c_forced: cover property (core_write_protect && write_protect_in_n);
	c_mode: cover property ($changed(iface_mode));
endmodule

bind fcr_floppy_cfg fcr_floppy_cfg_checker i_fcr_floppy_cfg_checker (
	.sys_clk(sys_clk), .arst_n(arst_n),
	.host_bus_reset_n(host_bus_reset_n),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_rvalid(io_rvalid),
	.config_port_base(config_port_base), .core_drive(core_drive),
	.write_protect_in_n(write_protect_in_n),
	.floppy_wp_disable(floppy_wp_disable),
	.core_write_protect(core_write_protect),
	.floppy_status_a_wp(floppy_status_a_wp), .enhanced_mode(enhanced_mode),
	.non_burst_dma(non_burst_dma), .iface_mode(iface_mode),
	.boot_drive(boot_drive)
);

// file: tb/test_fcr_floppy_cfg.sv
// Testbench for the floppy configuration registers
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; \
	if ((s) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", nm, e, s); end end
module test_fcr_floppy_cfg
	import fcr_pkg::*;
;
	logic        sys_clk = 0, arst_n = 0, hbr_n = 1, soft_reset = 0;
	logic [15:0] io_addr = 16'h0;
	logic        io_wr = 0, io_rd = 0, core_density = 0, wp_in_n = 1;
	logic        wp_dis = 0, pport_route = 0, io_rvalid, cwp, swp, dens;
	logic [7:0]  io_wdata = 8'h0, io_rdata;
	logic [15:0] base, new_base = 16'h0;
	logic        base_ld = 0, dens_oe, pdens;
	fcr_drive_t  core_drive = 4'hf, drv, oe, pdrv;
	logic        enh, nbd, boot;
	logic [1:0]  ifm;
	int          error_cnt = 0, n_compared = 0;
	fcr_floppy_cfg i_fcr_floppy_cfg (.sys_clk(sys_clk), .arst_n(arst_n),
		.host_bus_reset_n(hbr_n), .soft_reset(soft_reset),
		.config_port_strap(1'b0), .port_base_new(new_base),
		.port_base_load(base_ld),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid), .config_port_base(base),
		.core_drive(core_drive), .core_density(core_density),
		.write_protect_in_n(wp_in_n), .floppy_wp_disable(wp_dis),
		.pport_route(pport_route), .core_write_protect(cwp),
		.floppy_status_a_wp(swp), .drive_out(drv), .drive_oe(oe),
		.density_out(dens), .density_oe(dens_oe), .pport_drive_out(pdrv),
		.pport_density_out(pdens), .enhanced_mode(enh), .non_burst_dma(nbd),
		.iface_mode(ifm), .boot_drive(boot));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task finish_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task put(input logic [15:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1;
		@(posedge sys_clk) #1;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		put(base, i);
		put(base + 16'h1, d);
		io_wr = 0;
	endtask
	task rd(input logic [7:0] i, input logic [7:0] e);
		int n;
		put(base, i);
		io_wr = 0;
		io_addr = base + 16'h1;
		io_rd = 1;
		@(posedge sys_clk) #1 io_rd = 0;
		n = 0;
		while (io_rvalid !== 1'b1 && n < 4) begin
			n++;
			@(posedge sys_clk) #1;
		end
		if (n > 0) begin
			error_cnt++;
			finish_test;
		end
		`CHK("rdata", e, io_rdata)
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 arst_n = 1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK("base", FCR_PORT_STRAP0, base)
		rd(FCR_IDX_MODE, FCR_RST_MODE);
		rd(FCR_IDX_OPTION, FCR_RST_OPTION);
		rd(FCR_IDX_TYPE, FCR_RST_TYPE);
		`CHK("boot", 1'b0, boot)
		for (int k = 0; k < 4; k++) begin
			wr(FCR_IDX_MODE, 8'(k * 5));
			`CHK("ifm", 2'(k), ifm)
			`CHK("enh", 1'(k), enh)
			`CHK("nbd", 1'(k >> 1), nbd)
		end
		core_drive = 4'b0110;
		wr(FCR_IDX_MODE, 8'h00);
		`CHK("drv", 4'b0110, drv)
		`CHK("oe_od", 4'b1001, oe)
		`CHK("doe_od", 1'b1, dens_oe)
		wr(FCR_IDX_MODE, 8'h50);
		`CHK("drv_x", 4'b1001, drv)
		`CHK("oe_pp", 4'hf, oe)
		wr(FCR_IDX_MODE, 8'h80);
		`CHK("oe_z", 4'h0, oe)
		`CHK("doe_z", 1'b0, dens_oe)
		pport_route = 1;
		#1 `CHK("pdrv", 4'b0110, pdrv)
		`CHK("pdens", 1'b0, pdens)
		wr(FCR_IDX_OPTION, 8'h01);
		`CHK("wp_d0", 1'b1, cwp)
		pport_route = 0;
		core_drive = 4'b1001;
		#1 `CHK("wp_d1", 1'b1, swp)
		core_drive = 4'hf;
		#1 `CHK("wp_none", 1'b0, cwp)
		for (int c = 0; c < 8; c++) begin
			core_density = c[0];
			wr(FCR_IDX_OPTION, 8'hf2 | 8'(c >> 1 << 2));
			`CHK("dens", (c < 4) ? c[0] : (c < 6), dens)
		end
		rd(FCR_IDX_OPTION, 8'hfe);
		wr(FCR_IDX_TYPE, 8'h39);
		rd(FCR_IDX_TYPE, 8'h39);
		soft_reset = 1;
		@(posedge sys_clk) #1 soft_reset = 0;
		rd(FCR_IDX_TYPE, 8'h39);
		wr(FCR_IDX_LDN, 8'h01);
		wr(FCR_IDX_TYPE, 8'h00);
		rd(FCR_IDX_TYPE, 8'h00);
		wr(FCR_IDX_LDN, FCR_LDN_FLOPPY);
		rd(FCR_IDX_TYPE, 8'h39);
		hbr_n = 0;
		@(posedge sys_clk) #1 hbr_n = 1;
		rd(FCR_IDX_TYPE, FCR_RST_TYPE);
		rd(FCR_IDX_MODE, FCR_RST_MODE);
		new_base = 16'h0100;
		base_ld = 1;
		@(posedge sys_clk) #1 base_ld = 0;
		`CHK("base_mv", 16'h0100, base)
		rd(FCR_IDX_MODE, FCR_RST_MODE);
		finish_test;
	end
endmodule
